// [src/wpc_panel.v]
// panel control: lock sequence, speed/profile, horn, actuators, beeps
// assumes buttons and joystick come from pins; config ports are static
`timescale 1ns/10ps
`default_nettype none
`include "wpc_regs.vh"
module wpc_panel #(
   parameter HOLD_CYC   = `WPC_HOLD_CYC,
   parameter BEEP_CYC   = `WPC_BEEP_CYC,
   parameter LBEEP_CYC  = `WPC_LBEEP_CYC,
   parameter RIPPLE_CYC = `WPC_RIPPLE_CYC,
   parameter JW         = 8
) (
   input  wire          clock,
   input  wire          resetn,
   input  wire          clock_enable,
   input  wire          power_on,
   input  wire          onoff_button,
   input  wire          horn_button,
   input  wire          inc_button,
   input  wire          dec_button,
   input  wire          act_left_button,
   input  wire          act_right_button,
   input  wire [JW-1:0] joy_fwd,
   input  wire [JW-1:0] joy_rev,
   input  wire [JW-1:0] joy_left,
   input  wire [JW-1:0] joy_right,
   input  wire          cfg_profile_mode,
   input  wire [2:0]    cfg_profile_count,
   input  wire          cfg_block_buttons_driving,
   input  wire [1:0]    cfg_actuator_count,
   input  wire          cfg_joy_select,
   input  wire          speed_limited,
   input  wire          lock_stored,
   output reg           lock_store_value,
   output reg           lock_store_write,
   output reg           beep,
   output reg           horn,
   output reg           brake,
   output reg  [JW-1:0] drive_demand,
   output reg           drive_reverse,
   output reg  [4:0]    indicator,
   output reg  [2:0]    step_value,
   output reg           act_led_left,
   output reg           act_led_right,
   output reg  [JW-1:0] act_demand_left,
   output reg  [JW-1:0] act_demand_right,
   output reg           act_reverse,
   output reg           locked
);
   // ************************************************
   // constants and helpers
   // ************************************************
   localparam [JW-1:0] THRESH = `WPC_DEFL_THRESH;
   localparam [23:0]   HOLD_L = HOLD_CYC[23:0];
   localparam [23:0]   BEEP_L = BEEP_CYC[23:0];
   localparam [23:0]   LBEP_L = LBEEP_CYC[23:0];
   localparam [23:0]   RIPL_L = RIPPLE_CYC[23:0];
   localparam [6:0] S_OFF    = 7'h01;
   localparam [6:0] S_DRIVE  = 7'h02;
   localparam [6:0] S_HOLD   = 7'h04;
   localparam [6:0] S_SEQ_F  = 7'h08;
   localparam [6:0] S_SEQ_R  = 7'h10;
   localparam [6:0] S_SEQ_C  = 7'h20;
   localparam [6:0] S_ADJ    = 7'h40;

   function deflected;
      input [JW-1:0] v;
      begin
         deflected = (v >= THRESH);
      end
   endfunction

   function [2:0] sat_step;
      input [2:0] cur;
      input       up;
      input [2:0] top;
      begin
         if (up)
            sat_step = (cur >= top) ? top : cur + 3'h1;
         else
            sat_step = (cur <= `WPC_STEP_MIN) ? `WPC_STEP_MIN : cur - 3'h1;
      end
   endfunction

   // ************************************************
   // pin synchronisers
   // ************************************************
   reg [6:0]    btn_meta;
   reg [6:0]    btn_sync;
   reg [6:0]    btn_prev;
   reg [JW-1:0] jf_meta, jr_meta, jl_meta, jrt_meta;
   reg [JW-1:0] jf, jr, jl, jrt;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         btn_meta <= 7'h00;
         btn_sync <= 7'h00;
         btn_prev <= 7'h00;
         jf_meta  <= {JW{1'b0}};
         jr_meta  <= {JW{1'b0}};
         jl_meta  <= {JW{1'b0}};
         jrt_meta <= {JW{1'b0}};
         jf       <= {JW{1'b0}};
         jr       <= {JW{1'b0}};
         jl       <= {JW{1'b0}};
         jrt      <= {JW{1'b0}};
      end else if (clock_enable) begin
         btn_meta <= {power_on, onoff_button, horn_button, inc_button, dec_button,
                      act_left_button, act_right_button};
         btn_sync <= btn_meta;
         btn_prev <= btn_sync;
         jf_meta  <= joy_fwd;
         jr_meta  <= joy_rev;
         jl_meta  <= joy_left;
         jrt_meta <= joy_right;
         jf       <= jf_meta;
         jr       <= jr_meta;
         jl       <= jl_meta;
         jrt      <= jrt_meta;
      end
   end
   wire pwr      = btn_sync[6];
   wire onoff    = btn_sync[5];
   wire horn_s   = btn_sync[4];
   wire inc_p    = btn_sync[3] & ~btn_prev[3];
   wire dec_p    = btn_sync[2] & ~btn_prev[2];
   wire al_p     = btn_sync[1] & ~btn_prev[1];
   wire ar_p     = btn_sync[0] & ~btn_prev[0];
   wire pwr_rise = pwr & ~btn_prev[6];
   wire centred  = ~deflected(jf) & ~deflected(jr) & ~deflected(jl) & ~deflected(jrt);

   // ************************************************
   // timers: hold, beep, ripple
   // ************************************************
   reg         hold_start, beep_start, long_sel;
   wire        hold_busy, hold_done, beep_busy, ripl_busy, ripl_done;
   wpc_timer #(.WIDTH(24)) u_hold (
      .clock(clock), .resetn(resetn), .enable(clock_enable),
      .start(hold_start), .load(HOLD_L), .busy(hold_busy), .done(hold_done));
   wpc_timer #(.WIDTH(24)) u_beep (
      .clock(clock), .resetn(resetn), .enable(clock_enable),
      .start(beep_start), .load(long_sel ? LBEP_L : BEEP_L),
      .busy(beep_busy), .done());
   wpc_timer #(.WIDTH(24)) u_ripl (
      .clock(clock), .resetn(resetn), .enable(clock_enable),
      .start(ripl_done | ~ripl_busy), .load(RIPL_L),
      .busy(ripl_busy), .done(ripl_done));

   // ************************************************
   // main state machine
   // ************************************************
   reg [6:0] state, next_state;
   reg       seq_unlock;
   reg       act_sel_right;
   reg [2:0] ripple_pos;
   reg       ripple_up;
   reg       lock_pend;
   wire      act_en  = (cfg_actuator_count != 2'h0);
   wire      act_two = (cfg_actuator_count == 2'h2);
   wire [2:0] top    = cfg_profile_mode ?
                       ((cfg_profile_count > `WPC_STEP_MAX) ? `WPC_STEP_MAX :
                        (cfg_profile_count == 3'h0) ? `WPC_STEP_MIN : cfg_profile_count)
                       : `WPC_STEP_MAX;
   wire      driving = (state == S_DRIVE) & ~centred;
   wire      btn_ok  = ~(cfg_block_buttons_driving & driving);

   always @* begin
      next_state = state;
      hold_start = 1'b0;
      beep_start = 1'b0;
      long_sel   = 1'b0;
      case (state)
         S_OFF: begin
            if (pwr_rise) begin
               next_state = locked ? S_SEQ_F : S_DRIVE;
            end
         end
         S_DRIVE: begin
            if (onoff & ~btn_prev[5]) begin
               next_state = S_HOLD;
               hold_start = 1'b1;
            end else if (act_en & ~locked & (al_p | ar_p)) begin
               next_state = S_ADJ;
            end
         end
         S_HOLD: begin
            if (hold_done) begin
               beep_start = 1'b1;
            end
            if (!onoff) begin
               next_state = (hold_busy | hold_start) ? S_DRIVE :
                            (lock_pend ? S_SEQ_F : S_DRIVE);
            end
         end
         S_SEQ_F: begin
            if (deflected(jf)) begin
               beep_start = 1'b1;
               next_state = S_SEQ_R;
            end
         end
         S_SEQ_R: begin
            if (deflected(jr)) begin
               beep_start = 1'b1;
               next_state = S_SEQ_C;
            end
         end
         S_SEQ_C: begin
            if (centred) begin
               beep_start = 1'b1;
               long_sel   = 1'b1;
               next_state = S_DRIVE;
            end
         end
         S_ADJ: begin
            if (!act_en) begin
               next_state = S_DRIVE;
            end else if (!act_two & (al_p | ar_p)) begin
               next_state = S_DRIVE;
            end else if ((al_p & ~act_sel_right) | (ar_p & act_sel_right)) begin
               next_state = S_DRIVE;
            end
         end
         default: next_state = S_OFF;
      endcase
      if (!pwr) begin
         next_state = S_OFF;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state            <= S_OFF;
         seq_unlock       <= 1'b0;
         locked           <= 1'b0;
         lock_pend        <= 1'b0;
         lock_store_value <= 1'b0;
         lock_store_write <= 1'b0;
         step_value       <= `WPC_STEP_RESET;
         act_sel_right    <= 1'b0;
         ripple_pos       <= 3'h0;
         ripple_up        <= 1'b1;
         beep             <= 1'b0;
      end else if (clock_enable) begin
         state            <= next_state;
         lock_store_write <= 1'b0;
         beep             <= beep_busy;
         if (state == S_OFF) begin
            locked <= lock_stored;
         end
         if (state == S_HOLD && hold_done) begin
            lock_pend <= 1'b1;
         end else if (state != S_HOLD) begin
            lock_pend <= 1'b0;
         end
         if (next_state == S_SEQ_F && state != S_SEQ_F) begin
            seq_unlock <= locked;
         end
         if (state == S_SEQ_C && centred) begin
            locked           <= ~seq_unlock;
            lock_store_value <= ~seq_unlock;
            lock_store_write <= 1'b1;
         end
         if (state == S_DRIVE && btn_ok && !locked) begin
            if (inc_p & ~dec_p) begin
               step_value <= sat_step(step_value, 1'b1, top);
            end else if (dec_p & ~inc_p) begin
               step_value <= sat_step(step_value, 1'b0, top);
            end
         end else if (step_value > top) begin
            step_value <= top;
         end
         if (state == S_DRIVE && next_state == S_ADJ) begin
            act_sel_right <= ar_p & ~al_p;
         end else if (state == S_ADJ && act_two) begin
            if (al_p & act_sel_right) begin
               act_sel_right <= 1'b0;
            end else if (ar_p & ~act_sel_right) begin
               act_sel_right <= 1'b1;
            end else if (cfg_joy_select & deflected(jl)) begin
               act_sel_right <= 1'b0;
            end else if (cfg_joy_select & deflected(jrt)) begin
               act_sel_right <= 1'b1;
            end
         end
         if (ripl_done) begin
            if (ripple_up) begin
               ripple_pos <= ripple_pos + 3'h1;
               if (ripple_pos == 3'h3) ripple_up <= 1'b0;
            end else begin
               ripple_pos <= ripple_pos - 3'h1;
               if (ripple_pos == 3'h1) ripple_up <= 1'b1;
            end
         end
      end
   end

   // ************************************************
   // outputs: drive, horn, indicator, actuators
   // ************************************************
   wire drv_ok = (state == S_DRIVE) & ~locked;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         horn             <= 1'b0;
         brake            <= 1'b1;
         drive_demand     <= {JW{1'b0}};
         drive_reverse    <= 1'b0;
         indicator        <= 5'h00;
         act_led_left     <= 1'b0;
         act_led_right    <= 1'b0;
         act_demand_left  <= {JW{1'b0}};
         act_demand_right <= {JW{1'b0}};
         act_reverse      <= 1'b0;
      end else if (clock_enable) begin
         horn <= horn_s & pwr;
         // brake on when centred, whatever the mode
         brake <= centred | ~drv_ok;
         // demand follows deflection directly, so it is monotonic
         drive_demand  <= (drv_ok & ~centred) ? ((jf >= jr) ? jf : jr)
                          : {JW{1'b0}};
         drive_reverse <= drv_ok & (jr > jf);
         if (state == S_OFF) begin
            indicator <= 5'h00;
         end else if (locked) begin
            indicator <= 5'h01 << ripple_pos;
         end else if (speed_limited & ripple_pos[0]) begin
            indicator <= 5'h00;
         end else if (cfg_profile_mode) begin
            indicator <= 5'h01 << (step_value - 3'h1);
         end else begin
            indicator <= (5'h01 << step_value) - 5'h01;
         end
         act_led_left      <= (state == S_ADJ) & (~act_two | ~act_sel_right);
         act_led_right     <= (state == S_ADJ) & (~act_two | act_sel_right);
         act_demand_left   <= (state == S_ADJ & (~act_two | ~act_sel_right)) ?
                              ((jf >= jr) ? jf : jr) : {JW{1'b0}};
         act_demand_right  <= (state == S_ADJ & act_two & act_sel_right) ?
                              ((jf >= jr) ? jf : jr) : {JW{1'b0}};
         act_reverse       <= (state == S_ADJ) & (jr > jf);
      end
   end
endmodule // wpc_panel
`default_nettype wire

// [common/wpc_regs.vh]
// constants for the wheelchair panel control block
// assumes a 10 MHz system clock and plain-port configuration
`ifndef WPC_REGS_VH
`define WPC_REGS_VH
`define WPC_HOLD_MS       1000
`define WPC_CLK_KHZ       10000
`define WPC_HOLD_CYC      (`WPC_HOLD_MS * `WPC_CLK_KHZ)
`define WPC_BEEP_MS       50
`define WPC_BEEP_CYC      (`WPC_BEEP_MS * `WPC_CLK_KHZ)
`define WPC_LBEEP_MS      500
`define WPC_LBEEP_CYC     (`WPC_LBEEP_MS * `WPC_CLK_KHZ)
`define WPC_RIPPLE_MS     100
`define WPC_RIPPLE_CYC    (`WPC_RIPPLE_MS * `WPC_CLK_KHZ)
`define WPC_STEP_MIN      3'h1
`define WPC_STEP_MAX      3'h5
`define WPC_STEP_RESET    3'h1
`define WPC_DEFL_THRESH   8'h40
`endif

// [src/wpc_timer.v]
// down-counting timer with start pulse and done pulse
// assumes a single clock domain with clock enable
`timescale 1ns/10ps
`default_nettype none
module wpc_timer #(
   parameter WIDTH = 24
) (
   input  wire             clock,
   input  wire             resetn,
   input  wire             enable,
   input  wire             start,
   input  wire [WIDTH-1:0] load,
   output reg              busy,
   output reg              done
);
   reg [WIDTH-1:0] count;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count <= {WIDTH{1'b0}};
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (enable) begin
         done <= 1'b0;
         if (start) begin
            count <= load;
            busy  <= 1'b1;
         end else if (busy) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // wpc_timer
`default_nettype wire

// [bench/wpc_panel_properties.sv]
// port relations of the wheelchair panel block, bound to every instance
// assumes one clock, async active-low reset, clock_enable held high
`timescale 1ns/10ps
`default_nettype none
module wpc_panel_chk #(
   parameter HOLD_CYC = 20
) (
   input wire logic       clock,
   input wire logic       resetn,
   input wire logic       power_on,
   input wire logic       onoff_button,
   input wire logic       horn_button,
   input wire logic [7:0] joy_fwd,
   input wire logic [7:0] joy_rev,
   input wire logic [7:0] joy_left,
   input wire logic [7:0] joy_right,
   input wire logic [1:0] cfg_actuator_count,
   input wire logic       lock_store_write,
   input wire logic       beep,
   input wire logic       horn,
   input wire logic       brake,
   input wire logic [7:0] drive_demand,
   input wire logic [4:0] indicator,
   input wire logic [2:0] step_value,
   input wire logic       act_led_left,
   input wire logic       act_led_right,
   input wire logic [7:0] act_demand_left,
   input wire logic [7:0] act_demand_right,
   input wire logic       locked
);
   // ****************************************
   // helper logic and properties
   // ****************************************
   logic [7:0] hold_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // saturating, so a stuck button cannot wrap back into the window
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         hold_cnt <= 8'h00;
      else if (onoff_button && power_on && !locked)
         hold_cnt <= hold_cnt + {7'h00, hold_cnt != 8'hFF};
      else
         hold_cnt <= 8'h00;
   end
   sequence centred_s;
      joy_fwd < 8'h40 && joy_rev < 8'h40 && joy_left < 8'h40 && joy_right < 8'h40;
   endsequence
   sequence horn_held_s;
      (horn_button && power_on && !locked) [*6];
   endsequence
   hold_beep_a: assert property (hold_cnt == HOLD_CYC + 3 |-> ##[0:6] beep)
      else $error("no beep after on/off hold");
   horn_on_a: assert property (horn_held_s |-> horn)
      else $error("horn silent while held");
   horn_off_a: assert property (!horn_button [*5] |-> !horn)
      else $error("horn without button");
   brake_centre_a: assert property (centred_s [*5] |-> brake)
      else $error("brake off with stick centred");
   step_range_a: assert property (step_value >= 3'h1 && step_value <= 3'h5)
      else $error("step out of range");
   step_one_a: assert property (step_value != $past(step_value) |->
      (step_value == $past(step_value) + 3'h1 || step_value == $past(step_value) - 3'h1))
      else $error("step moved by more than one");
   locked_step_a: assert property (locked |=> $stable(step_value))
      else $error("step changed while locked");
   locked_drive_a: assert property (locked |-> drive_demand == 8'h00)
      else $error("drive demand while locked");
   ripple_a: assert property ((locked && power_on) [*5] |-> $onehot(indicator))
      else $error("locked pattern not one-hot");
   store_pulse_a: assert property (lock_store_write |=> !lock_store_write)
      else $error("lock store write too long");
   led_single_a: assert property (cfg_actuator_count == 2'h2 |->
      !(act_led_left && act_led_right))
      else $error("two leds lit with two actuators");
   act_none_a: assert property (cfg_actuator_count == 2'h0 |-> !act_led_left &&
      !act_led_right && act_demand_left == 8'h00 && act_demand_right == 8'h00)
      else $error("actuator activity without actuators");
endmodule // wpc_panel_chk
bind wpc_panel wpc_panel_chk #(.HOLD_CYC(HOLD_CYC)) chk (.*);
`default_nettype wire

// [bench/wpc_user.sv]
// model of the user at the panel plus the nonvolatile lock cell
// assumes its tasks are called at a falling clock edge
`timescale 1ns/10ps
`default_nettype none
module wpc_user (
   input  wire logic       clock,
   input  wire logic       lock_store_value,
   input  wire logic       lock_store_write,
   output var  logic       lock_stored,
   output var  logic       power_on,
   output var  logic       onoff_button,
   output var  logic       horn_button,
   output var  logic       inc_button,
   output var  logic       dec_button,
   output var  logic       act_left_button,
   output var  logic       act_right_button,
   output var  logic [7:0] joy_fwd,
   output var  logic [7:0] joy_rev,
   output var  logic [7:0] joy_left,
   output var  logic [7:0] joy_right
);
   // ****************************************
   // pins and lock cell
   // ****************************************
   // the cell ignores reset and power: it must survive both
   initial begin
      lock_stored = 1'b0;
      {power_on, onoff_button, horn_button, inc_button, dec_button} = 5'h00;
      {act_left_button, act_right_button} = 2'h0;
      {joy_fwd, joy_rev, joy_left, joy_right} = 32'h0;
   end
   always @(posedge clock) begin
      if (lock_store_write)
         lock_stored <= lock_store_value;
   end
   task automatic set_btn(input int b, input logic v);
      case (b)
         0: onoff_button = v;
         1: horn_button = v;
         2: inc_button = v;
         3: dec_button = v;
         4: act_left_button = v;
         5: act_right_button = v;
         default: power_on = v;
      endcase
   endtask
   task automatic press(input int b, input int n);
      @(negedge clock);
      set_btn(b, 1'b1);
      repeat (n) @(negedge clock);
      set_btn(b, 1'b0);
      repeat (6) @(negedge clock);
   endtask
   task automatic aim(input logic [7:0] f, r, l, rt);
      @(negedge clock);
      {joy_fwd, joy_rev, joy_left, joy_right} = {f, r, l, rt};
   endtask
   task automatic stick(input logic [7:0] f, r, l, rt);
      aim(f, r, l, rt);
      repeat (8) @(negedge clock);
   endtask
endmodule // wpc_user
`default_nettype wire

// [bench/wpc_panel_test.sv]
// self-checking bench for the wheelchair panel block
// assumes the user model drives all pins; counts are shortened
`timescale 1ns/10ps
`default_nettype none
module wpc_panel_test;
   // ****************************************
   // signals, design and user
   // ****************************************
   localparam logic [7:0] zero = 8'h00;
   logic clock = 1'b0, resetn = 1'b0, clock_enable = 1'b1, speed_limited = 1'b0;
   logic cfg_profile_mode = 1'b0, cfg_block_buttons_driving = 1'b0, cfg_joy_select = 1'b0;
   logic [2:0] cfg_profile_count = 3'h5;
   logic [1:0] cfg_actuator_count = 2'h0;
   int num_errors = 0, tests_run = 0, cycles = 0, beep_len;
   wire logic beep, horn, brake, drive_reverse, act_led_left, act_led_right, act_reverse;
   wire logic locked, lock_store_value, lock_store_write, lock_stored, power_on;
   wire logic onoff_button, horn_button, inc_button, dec_button;
   wire logic act_left_button, act_right_button;
   wire logic [7:0] joy_fwd, joy_rev, joy_left, joy_right;
   wire logic [7:0] drive_demand, act_demand_left, act_demand_right;
   wire logic [4:0] indicator;
   wire logic [2:0] step_value;
   wire logic [1:0] leds = {act_led_left, act_led_right};
   wpc_panel #(.HOLD_CYC(20), .BEEP_CYC(4), .LBEEP_CYC(8), .RIPPLE_CYC(4)) dut (.*);
   wpc_user u (.*);
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_sim;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic await_beep(input logic long);
      int i;
      i = 0;
      beep_len = 0;
      while (beep !== 1'b1 && i < 40) begin
         @(negedge clock);
         i++;
      end
      while (beep === 1'b1 && beep_len < 40) begin
         @(negedge clock);
         beep_len++;
      end
      check(beep, 1'b0);
      check(beep_len > 5, long);
   endtask
   task automatic end_sim;
      $display("checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset;
      @(negedge clock);
      check({horn, beep, locked, brake, step_value}, 8'h09);
      u.set_btn(6, 1'b1);
      repeat (10) @(negedge clock);
      check(indicator, 5'h01);
      $display("test reset done");
   endtask
   task automatic t_horn;
      u.set_btn(1, 1'b1);
      repeat (6) @(negedge clock);
      check(horn, 1'b1);
      u.set_btn(1, 1'b0);
      repeat (6) @(negedge clock);
      check(horn, 1'b0);
      $display("test horn done");
   endtask
   task automatic t_speed;
      repeat (6) u.press(2, 4);
      check(step_value, 3'h5);
      check(indicator, 5'h1F);
      repeat (6) u.press(3, 4);
      check(step_value, 3'h1);
      check(indicator, 5'h01);
      cfg_block_buttons_driving = 1'b1;
      u.stick(8'h80, zero, zero, zero);
      u.press(2, 4);
      check(step_value, 3'h1);
      cfg_block_buttons_driving = 1'b0;
      u.press(2, 4);
      check(step_value, 3'h2);
      u.stick(zero, zero, zero, zero);
      u.press(3, 4);
      cfg_profile_mode = 1'b1;
      cfg_profile_count = 3'h3;
      repeat (4) u.press(2, 4);
      check(indicator, 5'h04);
      u.press(3, 4);
      check(indicator, 5'h02);
      u.press(3, 4);
      cfg_profile_mode = 1'b0;
      $display("test speed done");
   endtask
   task automatic t_drive;
      u.stick(8'h50, zero, zero, zero);
      check(drive_demand, 8'h50);
      check(brake, 1'b0);
      u.stick(8'hA0, zero, zero, zero);
      check(drive_demand, 8'hA0);
      u.stick(zero, 8'h60, zero, zero);
      check(drive_demand, 8'h60);
      check(drive_reverse, 1'b1);
      u.stick(zero, zero, zero, zero);
      check({brake, drive_demand}, 9'h100);
      $display("test drive done");
   endtask
   task automatic t_act;
      cfg_actuator_count = 2'h1;
      u.press(4, 4);
      check(leds, 2'h3);
      u.stick(8'h70, zero, zero, zero);
      check(act_demand_left, 8'h70);
      check(drive_demand, zero);
      u.stick(zero, zero, zero, zero);
      u.press(5, 4);
      check(leds, 2'h0);
      cfg_actuator_count = 2'h2;
      u.press(4, 4);
      check(leds, 2'h2);
      u.stick(8'h70, zero, zero, zero);
      check({act_demand_left, act_demand_right}, 16'h7000);
      u.stick(zero, 8'h70, zero, zero);
      check({act_demand_left, act_reverse}, 9'h0E1);
      u.stick(zero, zero, zero, zero);
      u.press(5, 4);
      check(leds, 2'h1);
      u.stick(8'h70, zero, zero, zero);
      check({act_demand_left, act_demand_right}, 16'h0070);
      u.stick(zero, zero, zero, zero);
      cfg_joy_select = 1'b1;
      u.stick(zero, zero, 8'h80, zero);
      u.stick(zero, zero, zero, zero);
      check(leds, 2'h2);
      u.press(4, 4);
      check(leds, 2'h0);
      cfg_joy_select = 1'b0;
      cfg_actuator_count = 2'h0;
      u.press(4, 4);
      check(leds, 2'h0);
      $display("test actuator done");
   endtask
   task automatic t_limit;
      logic blank, lit;
      blank = 1'b0;
      lit = 1'b0;
      speed_limited = 1'b1;
      repeat (40) begin
         @(negedge clock);
         blank |= (indicator === 5'h00);
         lit |= (indicator === 5'h01);
      end
      check({blank, lit}, 2'h3);
      speed_limited = 1'b0;
      $display("test limit done");
   endtask
   // the unlock half starts from switch-on, so the power cycle sits between
   task automatic t_lock;
      u.set_btn(0, 1'b1);
      await_beep(1'b0);
      u.set_btn(0, 1'b0);
      u.aim(8'h80, zero, zero, zero);
      await_beep(1'b0);
      u.aim(zero, 8'h80, zero, zero);
      await_beep(1'b0);
      u.aim(zero, zero, zero, zero);
      await_beep(1'b1);
      repeat (4) @(negedge clock);
      check({locked, lock_stored}, 2'h3);
      u.set_btn(6, 1'b0);
      repeat (8) @(negedge clock);
      u.set_btn(6, 1'b1);
      repeat (8) @(negedge clock);
      check(locked, 1'b1);
      check($onehot(indicator), 1'b1);
      u.press(2, 4);
      check(step_value, 3'h1);
      u.aim(8'h80, zero, zero, zero);
      await_beep(1'b0);
      check(drive_demand, zero);
      u.aim(zero, 8'h80, zero, zero);
      await_beep(1'b0);
      u.aim(zero, zero, zero, zero);
      await_beep(1'b1);
      repeat (4) @(negedge clock);
      check({locked, lock_stored}, 2'h0);
      $display("test lock done");
   endtask
   initial begin
      repeat (20) @(negedge clock);
      resetn = 1'b1;
      t_reset;
      t_horn;
      t_speed;
      t_drive;
      t_act;
      t_limit;
      t_lock;
      end_sim;
   end
endmodule // wpc_panel_test
`default_nettype wire
